// ===== rtl/pcl_top.sv
// Loop control interface: settings registers, lock tracking and clock routing
//
// Function
// R1 - Run control low holds the loop powered down and high lets it run.
// R2 - The six-bit feedback setting gives a multiplication factor equal to the field plus one.
// R3 - The six-bit output setting gives a division ratio equal to the field plus one.
// R4 - Input range select chooses 50-200 MHz when low and 14-50 MHz when high.
// R5 - Output range decodes xx0, 001, 011, 101 and 111 into five frequency bands.
// R6 - The five-bit shift setting is sign and magnitude, 250 ps a step, up to 15 steps.
// R7 - Lock status goes high when the loop has locked.
// R8 - User logic treats lock and both clocks as undefined when the reference is out of range.
// R9 - Each global network has its own loop at its root.
// R10 - Each clock pin pair drives either its global network or the loop reference.
// R11 - The loop reference may come from a user signal instead of a pin.
// R12 - The routed output carries either the first or the second loop clock.
// R13 - The loop output drives either the regular or the fast global network.
// R14 - Selectors pick the feedback, reference and routed sources and the global root.
// R15 - Feedback closes the loop and both clock outputs deliver the loop clocks.
// R16 - Lock status stays low while the loop is powered down.
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
module pcl_top
    import pcl_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Clock sources
    input wire logic reference_clock_in,
    input wire logic feedback_clock_in,
    input wire logic clock_pin_pair_positive,
    input wire logic clock_pin_pair_negative,
    input wire logic user_reference_in,
    // Loop outputs
    output logic lock_status,
    output logic first_synth_clock,
    output logic second_synth_clock,
    output logic routed_clock_out,
    output logic regular_global_clock,
    output logic fast_global_clock,
    output logic irq
);
    logic [CTRL_W-1:0] ctrl_q;
    logic [13:0] div_q;
    logic [4:0] shift_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic aw_got_q;
    logic w_got_q;
    logic wr_fire;
    logic wr_ok;
    logic relock;
    logic run;
    pcl_lock_e state_q;
    pcl_lock_e state_d;
    logic [CNT_W-1:0] lock_cnt_q;
    logic [CNT_W-1:0] ref_idle_q;
    logic [CNT_W-1:0] fb_idle_q;
    logic ref_prev_q;
    logic fb_prev_q;
    logic ref_sel;
    logic fb_sel;
    logic pair_level;
    logic first_clk;
    logic second_clk;
    logic gained;
    logic lost;
    logic [2:0] band_q;
    logic [6:0] fb_factor_q;
    logic [6:0] out_ratio_q;
    logic signed [15:0] shift_ps_q;
    logic [31:0] rd_d;
    logic rd_ok;

    assign run = ctrl_q[B_RUN];
    assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;

    // AXI write channels taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_got_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_got_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_got_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready <= !w_got_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_comb begin
        if (awaddr_q == ADDR_CTRL || awaddr_q == ADDR_DIV || awaddr_q == ADDR_SHIFT) begin
            wr_ok = 1'b1;
        end else if (awaddr_q == ADDR_STATUS || awaddr_q == ADDR_INFO) begin
            wr_ok = 1'b1;
        end else if (awaddr_q == ADDR_IRQ_STATUS || awaddr_q == ADDR_IRQ_MASK) begin
            wr_ok = 1'b1;
        end else begin
            wr_ok = 1'b0;
        end
    end

    // Settings registers; a write to ctrl or divider restarts acquisition
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= CTRL_RESET;
            div_q <= DIV_RESET;
            shift_q <= SHIFT_RESET;
            irq_mask_q <= '0;
        end else if (wr_fire) begin
            if (awaddr_q == ADDR_CTRL) begin
                if (wstrb_q[0]) ctrl_q[7:0] <= wdata_q[7:0]; // R1 R14
                if (wstrb_q[1]) ctrl_q[CTRL_W-1:8] <= wdata_q[CTRL_W-1:8];
            end else if (awaddr_q == ADDR_DIV) begin
                if (wstrb_q[0]) div_q[5:0] <= wdata_q[5:0]; // R2
                if (wstrb_q[1]) div_q[13:8] <= wdata_q[13:8]; // R3
            end else if (awaddr_q == ADDR_SHIFT) begin
                if (wstrb_q[0]) shift_q <= wdata_q[4:0]; // R6
            end else if (awaddr_q == ADDR_IRQ_MASK) begin
                if (wstrb_q[0]) irq_mask_q <= wdata_q[IRQ_W-1:0];
            end
        end
    end

    assign relock = wr_fire && (awaddr_q == ADDR_CTRL || awaddr_q == ADDR_DIV);

    // Reference and feedback source selection
    assign pair_level = clock_pin_pair_positive && !clock_pin_pair_negative;
    always_comb begin
        if (ctrl_q[B_INTREF]) begin
            ref_sel = user_reference_in; // R11
        end else if (ctrl_q[B_PAIRREF]) begin
            ref_sel = pair_level; // R10
        end else begin
            ref_sel = reference_clock_in;
        end
        fb_sel = ctrl_q[B_FBSRC] ? first_clk : feedback_clock_in; // R14 R15
    end

    // Activity watch on reference and feedback
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_prev_q <= 1'b0;
            fb_prev_q <= 1'b0;
            ref_idle_q <= '0;
            fb_idle_q <= '0;
        end else begin
            ref_prev_q <= ref_sel;
            fb_prev_q <= fb_sel;
            if (ref_sel && !ref_prev_q) begin
                ref_idle_q <= '0;
            end else if (ref_idle_q <= CNT_W'(LOSS_CYCLES)) begin
                ref_idle_q <= ref_idle_q + 1'b1;
            end
            if (fb_sel && !fb_prev_q) begin
                fb_idle_q <= '0;
            end else if (fb_idle_q <= CNT_W'(LOSS_CYCLES)) begin
                fb_idle_q <= fb_idle_q + 1'b1;
            end
        end
    end

    // Lock tracking
    always_comb begin
        state_d = state_q;
        case (state_q)
            PCL_OFF: begin
                if (run) state_d = PCL_ACQ;
            end
            PCL_ACQ: begin
                if (lock_cnt_q >= CNT_W'(LOCK_CYCLES - 1) && !relock) state_d = PCL_LOCKED;
            end
            PCL_LOCKED: begin
                if (relock || ref_idle_q > CNT_W'(LOSS_CYCLES) ||
                    fb_idle_q > CNT_W'(LOSS_CYCLES)) state_d = PCL_ACQ;
            end
            default: state_d = PCL_OFF;
        endcase
        if (!run) state_d = PCL_OFF; // R1 R16
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= PCL_OFF;
            lock_cnt_q <= '0;
            lock_status <= 1'b0;
        end else begin
            state_q <= state_d;
            lock_status <= (state_d == PCL_LOCKED); // R7 R16
            if (state_q != PCL_ACQ || relock || ref_idle_q > CNT_W'(LOSS_CYCLES) ||
                fb_idle_q > CNT_W'(LOSS_CYCLES)) begin
                lock_cnt_q <= '0;
            end else begin
                lock_cnt_q <= lock_cnt_q + 1'b1;
            end
        end
    end

    assign gained = (state_d == PCL_LOCKED) && !lock_status;
    assign lost = (state_d != PCL_LOCKED) && lock_status;

    // Loop clocks, powered down with run
    pcl_divider u_first (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(run),
        .ratio(div_q[DIV_OUT_LO+5:DIV_OUT_LO]),
        .clk_q(first_clk)
    ); // R3 R15
    pcl_divider u_second (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(run),
        .ratio(SECOND_RATIO),
        .clk_q(second_clk)
    );

    // Clock routing onto outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            first_synth_clock <= 1'b0;
            second_synth_clock <= 1'b0;
            routed_clock_out <= 1'b0;
            regular_global_clock <= 1'b0;
            fast_global_clock <= 1'b0;
        end else begin
            first_synth_clock <= first_clk; // R15
            second_synth_clock <= second_clk;
            routed_clock_out <= ctrl_q[B_ROUTED] ? second_clk : first_clk; // R12
            if (ctrl_q[B_GROOT]) begin
                regular_global_clock <= !ctrl_q[B_FAST] &&
                    (ctrl_q[B_GSRC] ? second_clk : first_clk); // R9 R13
                fast_global_clock <= ctrl_q[B_FAST] &&
                    (ctrl_q[B_GSRC] ? second_clk : first_clk); // R13
            end else begin
                regular_global_clock <= !ctrl_q[B_FAST] && !ctrl_q[B_PAIRREF] && pair_level; // R10
                fast_global_clock <= ctrl_q[B_FAST] && !ctrl_q[B_PAIRREF] && pair_level;
            end
        end
    end

    // Decoded settings for readback
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            band_q <= BAND_400_1000;
            fb_factor_q <= 7'h01;
            out_ratio_q <= 7'h01;
            shift_ps_q <= 16'sh0000;
        end else begin
            if (!ctrl_q[B_ORANGE_LO]) begin
                band_q <= BAND_400_1000; // R5
            end else if (ctrl_q[B_ORANGE_LO+2:B_ORANGE_LO+1] == 2'h0) begin
                band_q <= BAND_200_400;
            end else if (ctrl_q[B_ORANGE_LO+2:B_ORANGE_LO+1] == 2'h1) begin
                band_q <= BAND_100_200;
            end else if (ctrl_q[B_ORANGE_LO+2:B_ORANGE_LO+1] == 2'h2) begin
                band_q <= BAND_50_100;
            end else begin
                band_q <= BAND_20_50;
            end
            fb_factor_q <= {1'b0, div_q[5:0]} + 7'h01; // R2
            out_ratio_q <= {1'b0, div_q[DIV_OUT_LO+5:DIV_OUT_LO]} + 7'h01; // R3
            shift_ps_q <= shift_q[SHIFT_SIGN] ?
                16'(-($signed({12'h000, shift_q[3:0]}) * 16'sd250)) :
                16'($signed({12'h000, shift_q[3:0]}) * 16'sd250); // R6
        end
    end

    // Sticky events, write one to clear, set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_q <= '0;
            irq <= 1'b0;
        end else begin
            for (int i = 0; i < IRQ_W; i++) begin
                if ((i == IRQ_GAINED && gained) || (i == IRQ_LOST && lost)) begin
                    irq_stat_q[i] <= 1'b1;
                end else if (wr_fire && awaddr_q == ADDR_IRQ_STATUS && wstrb_q[0] &&
                             wdata_q[i]) begin
                    irq_stat_q[i] <= 1'b0;
                end
            end
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Read path
    always_comb begin
        rd_d = 32'h0000_0000;
        rd_ok = 1'b1;
        if (s_axi_araddr == ADDR_CTRL) begin
            rd_d[CTRL_W-1:0] = ctrl_q;
        end else if (s_axi_araddr == ADDR_DIV) begin
            rd_d[13:0] = div_q;
        end else if (s_axi_araddr == ADDR_SHIFT) begin
            rd_d[4:0] = shift_q;
        end else if (s_axi_araddr == ADDR_STATUS) begin
            rd_d[3:0] = {band_q, lock_status}; // R4 R5
            rd_d[4] = ctrl_q[B_INRANGE];
        end else if (s_axi_araddr == ADDR_INFO) begin
            rd_d[6:0] = fb_factor_q;
            rd_d[INFO_OUT_LO+6:INFO_OUT_LO] = out_ratio_q;
            rd_d[INFO_PS_LO+15:INFO_PS_LO] = shift_ps_q;
        end else if (s_axi_araddr == ADDR_IRQ_STATUS) begin
            rd_d[IRQ_W-1:0] = irq_stat_q;
        end else if (s_axi_araddr == ADDR_IRQ_MASK) begin
            rd_d[IRQ_W-1:0] = irq_mask_q;
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_d;
                s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    chk_lock_off: assert property (@(posedge aclk) disable iff (!aresetn) // R16
        !run |=> !lock_status) else $error("lock high while powered down");
    chk_lock_needs_run: assert property (@(posedge aclk) disable iff (!aresetn) // R7
        $rose(lock_status) |-> $past(run, 1) && $past(state_q, 1) == PCL_ACQ)
        else $error("lock rose without acquisition");
    chk_clock_down: assert property (@(posedge aclk) disable iff (!aresetn) // R1
        !run [*3] |-> !first_synth_clock && !second_synth_clock)
        else $error("clock runs while powered down");
    chk_fb_factor: assert property (@(posedge aclk) disable iff (!aresetn) // R2
        $stable(div_q) |=> fb_factor_q == {1'b0, $past(div_q[5:0])} + 7'h01)
        else $error("feedback factor wrong");
    chk_out_ratio: assert property (@(posedge aclk) disable iff (!aresetn) // R3
        $stable(div_q) |=> out_ratio_q == {1'b0, $past(div_q[13:8])} + 7'h01)
        else $error("output ratio wrong");
    chk_band_even: assert property (@(posedge aclk) disable iff (!aresetn) // R5
        !ctrl_q[B_ORANGE_LO] |=> band_q == BAND_400_1000) else $error("band decode wrong");
    chk_shift_sign: assert property (@(posedge aclk) disable iff (!aresetn) // R6
        shift_q[SHIFT_SIGN] && shift_q[3:0] == 4'hf |=> shift_ps_q == -16'sd3750)
        else $error("shift value wrong");
    chk_routed_src: assert property (@(posedge aclk) disable iff (!aresetn) // R12
        ##1 routed_clock_out == ($past(ctrl_q[B_ROUTED]) ? $past(second_clk) : $past(first_clk)))
        else $error("routed output source wrong");
    chk_global_excl: assert property (@(posedge aclk) disable iff (!aresetn) // R13
        !(regular_global_clock && fast_global_clock)) else $error("both global nets driven");
    chk_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write response dropped");
endmodule

// ===== rtl/pcl_pkg.sv
// Constants, register map and types for the loop control interface
package pcl_pkg;
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned LOCK_TIME_NS = 2000;
    localparam int unsigned LOSS_TIME_NS = 1000;
    localparam int unsigned LOCK_CYCLES = (LOCK_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned LOSS_CYCLES = (LOSS_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned STEP_PS = 250;
    localparam int CNT_W = 10;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DIV = 8'h04;
    localparam logic [7:0] ADDR_SHIFT = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_INFO = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
    localparam int CTRL_W = 12;
    localparam int B_RUN = 0;
    localparam int B_INRANGE = 1;
    localparam int B_ORANGE_LO = 2;
    localparam int B_INTREF = 5;
    localparam int B_FBSRC = 6;
    localparam int B_ROUTED = 7;
    localparam int B_GSRC = 8;
    localparam int B_GROOT = 9;
    localparam int B_PAIRREF = 10;
    localparam int B_FAST = 11;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h000;
    localparam int DIV_OUT_LO = 8;
    localparam logic [13:0] DIV_RESET = 14'h0000;
    localparam logic [4:0] SHIFT_RESET = 5'h00;
    localparam int SHIFT_SIGN = 4;
    localparam int INFO_OUT_LO = 8;
    localparam int INFO_PS_LO = 16;
    localparam int IRQ_W = 2;
    localparam int IRQ_GAINED = 0;
    localparam int IRQ_LOST = 1;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [2:0] BAND_400_1000 = 3'h0;
    localparam logic [2:0] BAND_200_400 = 3'h1;
    localparam logic [2:0] BAND_100_200 = 3'h2;
    localparam logic [2:0] BAND_50_100 = 3'h3;
    localparam logic [2:0] BAND_20_50 = 3'h4;
    localparam logic [5:0] SECOND_RATIO = 6'h00;
    typedef enum logic [2:0] {
        PCL_OFF = 3'b001,
        PCL_ACQ = 3'b010,
        PCL_LOCKED = 3'b100
    } pcl_lock_e;
endpackage

// ===== rtl/pcl_divider.sv
// Clock divider producing a square wave with a half period of ratio plus one cycles
`timescale 1ns/1ps
module pcl_divider
    import pcl_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic run,
    input wire logic [5:0] ratio,
    // Divided clock
    output logic clk_q
);
    logic [6:0] cnt_q;
    logic [6:0] half;

    // Half period is ratio plus one cycles
    assign half = {1'b0, ratio};

    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            cnt_q <= 7'h00;
            clk_q <= 1'b0;
        end else if (cnt_q >= half) begin
            cnt_q <= 7'h00;
            clk_q <= !clk_q;
        end else begin
            cnt_q <= cnt_q + 7'h01;
        end
    end
endmodule

// ===== testbench/pcl_clock_env.sv
// Reference and feedback clock sources standing in for the user side
`timescale 1ns/1ps
module pcl_clock_env (
    // Clock
    input wire logic aclk,
    // Control
    input wire logic hold,
    // Clock sources
    output logic reference_clock_in,
    output logic feedback_clock_in,
    output logic clock_pin_pair_positive,
    output logic clock_pin_pair_negative,
    output logic user_reference_in
);
    logic [1:0] div_q = 2'h0;
    logic ref_q = 1'b0;
    // Reference kept in range while running; stands still on hold
    always @(posedge aclk) begin
        if (!hold) begin
            div_q <= div_q + 2'h1;
            if (div_q == 2'h3) begin
                ref_q <= !ref_q;
            end
        end
    end
    assign reference_clock_in = ref_q;
    assign feedback_clock_in = ref_q;
    assign clock_pin_pair_positive = reference_clock_in;
    assign clock_pin_pair_negative = !reference_clock_in;
    assign user_reference_in = feedback_clock_in;
endmodule

// ===== testbench/tb_top.sv
// Self-checking bench for the loop control interface
`timescale 1ns/1ps
module tb_top;
    import pcl_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, hold = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic reference_clock_in, feedback_clock_in, clock_pin_pair_positive;
    logic clock_pin_pair_negative, user_reference_in, lock_status, first_synth_clock;
    logic second_synth_clock, routed_clock_out, regular_global_clock, fast_global_clock, irq;
    int failures = 0, checked = 0, n;
    always #2.5 aclk = ~aclk;
    pcl_top pcl_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .reference_clock_in, .feedback_clock_in,
        .clock_pin_pair_positive, .clock_pin_pair_negative, .user_reference_in, .lock_status,
        .first_synth_clock, .second_synth_clock, .routed_clock_out, .regular_global_clock,
        .fast_global_clock, .irq);
    pcl_clock_env pcl_clock_env_i (.aclk, .hold, .reference_clock_in, .feedback_clock_in,
        .clock_pin_pair_positive, .clock_pin_pair_negative, .user_reference_in);
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic timeout();
        failures++;
        $display("wait limit ran out");
        final_report();
    endtask
    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        int k;
        s_axi_awaddr <= addr;
        s_axi_wdata <= data;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (k == 50) timeout();
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] addr);
        int k;
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (k == 50) timeout();
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    // Cycles until lock_status reaches the wanted level
    task automatic wait_lock(input logic want, input int lim);
        for (n = 0; n < lim && lock_status !== want; n++) @(posedge aclk);
        if (n == lim) timeout();
    endtask
    task automatic t_reset();
        rd(ADDR_CTRL);
        check("ctrl reset", rdat, 32'(CTRL_RESET));
        rd(ADDR_DIV);
        check("div reset", rdat, 32'(DIV_RESET));
        check("lock idle", 32'(lock_status), 32'h0);
        check("irq idle", 32'(irq), 32'h0);
        $display("reset test done");
    endtask
    task automatic t_div();
        logic [5:0] v, w;
        logic [5:0] tbl [3] = '{6'h00, 6'h3f, 6'h15};
        for (int i = 0; i < 3; i++) begin
            v = tbl[i];
            w = ~v;
            wr(ADDR_DIV, {18'h0, w, 2'b00, v});
            rd(ADDR_INFO);
            check("fb factor", 32'(rdat[6:0]), 32'(v) + 32'h1);
            check("out ratio", 32'(rdat[14:8]), 32'(w) + 32'h1);
        end
        $display("divider test done");
    endtask
    task automatic t_shift();
        int ps;
        logic [4:0] tbl [5] = '{5'h00, 5'h01, 5'h0f, 5'h11, 5'h1f};
        for (int i = 0; i < 5; i++) begin
            ps = int'(tbl[i][3:0]) * int'(STEP_PS);
            if (tbl[i][SHIFT_SIGN]) ps = -ps;
            wr(ADDR_SHIFT, {27'h0, tbl[i]});
            rd(ADDR_INFO);
            check("shift ps", {16'h0, rdat[31:16]}, {16'h0, 16'(ps)});
        end
        $display("shift test done");
    endtask
    task automatic t_ranges();
        logic [2:0] oc, band;
        for (int c = 0; c < 8; c++) begin
            oc = 3'(c);
            wr(ADDR_CTRL, {27'h0, oc, oc[0], 1'b0});
            rd(ADDR_STATUS);
            band = oc[0] ? {1'b0, oc[2:1]} + 3'h1 : BAND_400_1000;
            check("band", 32'(rdat[3:1]), 32'(band));
            check("input range", 32'(rdat[4]), 32'(oc[0]));
        end
        $display("range test done");
    endtask
    task automatic t_lock();
        logic v;
        wr(ADDR_DIV, 32'h0000_0200);
        wr(ADDR_IRQ_MASK, 32'h3);
        wr(ADDR_CTRL, 32'h0000_0b81);
        wait_lock(1'b1, 1000);
        check("lock time", 32'(n >= int'(LOCK_CYCLES) - 10), 32'h1);
        rd(ADDR_IRQ_STATUS);
        check("gained flag", rdat, 32'h1);
        check("irq raised", 32'(irq), 32'h1);
        wr(ADDR_IRQ_MASK, 32'h0);
        check("irq masked", 32'(irq), 32'h0);
        wr(ADDR_IRQ_STATUS, 32'h1);
        rd(ADDR_IRQ_STATUS);
        check("gained clear", rdat, 32'h0);
        v = first_synth_clock;
        for (n = 0; n < 50 && first_synth_clock === v; n++) @(posedge aclk);
        if (n == 50) timeout();
        v = first_synth_clock;
        for (n = 0; n < 50 && first_synth_clock === v; n++) @(posedge aclk);
        check("half period", 32'(n), 32'h3);
        for (int i = 0; i < 4; i++) begin
            v = routed_clock_out;
            @(posedge aclk);
            check("routed toggle", 32'(routed_clock_out), 32'(!v));
            check("regular idle", 32'(regular_global_clock), 32'h0);
            check("fast follows", 32'(fast_global_clock), 32'(!v));
            check("second toggles", 32'(second_synth_clock), 32'(!v));
        end
        wr(ADDR_IRQ_MASK, 32'h3);
        hold <= 1'b1;
        wait_lock(1'b0, 600);
        rd(ADDR_IRQ_STATUS);
        check("lost flag", 32'(rdat[IRQ_LOST]), 32'h1);
        check("irq lost", 32'(irq), 32'h1);
        hold <= 1'b0;
        wr(ADDR_IRQ_STATUS, 32'h3);
        wait_lock(1'b1, 1000);
        wr(ADDR_CTRL, 32'h0);
        check("lock off", 32'(lock_status), 32'h0);
        $display("lock test done");
    endtask
    task automatic t_route();
        logic v;
        wr(ADDR_CTRL, 32'h0000_0041);
        for (int i = 0; i < 12; i++) begin
            v = reference_clock_in;
            @(posedge aclk);
            check("pair to regular", 32'(regular_global_clock), 32'(v));
            check("fast idle", 32'(fast_global_clock), 32'h0);
        end
        wait_lock(1'b1, 1000);
        check("lock on first clock", 32'(lock_status), 32'h1);
        $display("route test done");
    endtask
    task automatic t_unmapped();
        wr(8'h1c, 32'h5a5a_a5a5);
        check("write resp", 32'(resp), 32'(RESP_SLVERR));
        rd(8'h1c);
        check("read resp", 32'(resp), 32'(RESP_SLVERR));
        $display("unmapped test done");
    endtask
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_div();
        t_shift();
        t_ranges();
        t_lock();
        t_route();
        t_unmapped();
        final_report();
    end
endmodule
